// >>> tsc_map.svh
// register map, field positions and frame counts of the serial config port
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH
`define TSC_ADDR_RXTX0 5'h00
`define TSC_ADDR_RXTX1 5'h01
`define TSC_ADDR_FREQ0 5'h02
`define TSC_ADDR_FREQ1 5'h03
`define TSC_ADDR_FREQ2 5'h04
`define TSC_ADDR_STATUS 5'h05
`define TSC_ADDR_EXTRA0 5'h06
`define TSC_ADDR_EXTRA1 5'h07
`define TSC_ADDR_PAT0 5'h08
`define TSC_ADDR_PAT1 5'h09
`define TSC_ADDR_PAT2 5'h0A
`define TSC_ADDR_PAT3 5'h0B
`define TSC_ADDR_TEST 5'h10
`define TSC_NUM_BYTES 12
`define TSC_RESET_BYTE 8'h00
`define TSC_RXTX0_BSYNC 6
`define TSC_RXTX1_PREF 5
`define TSC_RXTX1_STAIR 3
`define TSC_RXTX1_CLKOUT 0
`define TSC_EXTRA0_MATCH 7
`define TSC_EXTRA0_LEN_HI 6
`define TSC_EXTRA0_LEN_LO 5
`define TSC_EXTRA0_TOL_HI 4
`define TSC_EXTRA0_TOL_LO 3
`define TSC_EXTRA0_DIV_HI 2
`define TSC_EXTRA0_DIV_LO 1
`define TSC_MODE_SLEEP 3'h0
`define TSC_ADDR_LAST 3'h4
`define TSC_DATA_LAST 3'h7
`define TSC_STOP_LAST 3'h1
`define TSC_DIV_HALF_MAX 5'h10
`define TSC_PAT_BITS 32
`endif

// >>> tsc_pkg.sv
// types shared by the serial config port and its helpers
`include "tsc_map.svh"
package tsc_pkg;
    typedef logic [7:0] tsc_byte_type;
    typedef enum logic [2:0] {
        TSC_IDLE = 3'b000,
        TSC_DIR = 3'b001,
        TSC_ADDR = 3'b010,
        TSC_DATA = 3'b011,
        TSC_STOP = 3'b100,
        TSC_READ = 3'b101
    } tsc_state_type;
    typedef struct packed {
        logic sck_q;
        logic en_n_q;
        tsc_state_type state;
        logic [2:0] cnt;
        logic rw;
        logic [4:0] addr;
        logic [7:0] data;
        logic so;
        logic [`TSC_NUM_BYTES-1:0][7:0] shadow;
        logic [`TSC_NUM_BYTES-1:0][7:0] active;
    } tsc_port_state_type;
    typedef struct packed {
        logic [`TSC_PAT_BITS-1:0] hist;
        logic [5:0] fill;
        logic match;
    } tsc_match_state_type;
    typedef struct packed {
        logic ref_q;
        logic [4:0] cnt;
        logic out;
    } tsc_div_state_type;
endpackage

// >>> tsc_pattern_match.sv
// received-bit pattern matcher with programmable length and tolerance
`timescale 1ns/100ps
`include "tsc_map.svh"
module tsc_pattern_match #(
    parameter int W = `TSC_PAT_BITS
) (
    input wire logic clock, // system clock
    input wire logic rst, // synchronous reset
    input wire logic enable, // match on and bit sync on
    input wire logic bit_in, // recovered nrz bit
    input wire logic bit_valid, // one-cycle strobe per bit
    input wire logic [W-1:0] pattern, // first-sent bit at msb
    input wire logic [1:0] length_sel, // 8,16,24,32 bits
    input wire logic [1:0] tolerance, // 0..3 bit errors
    output logic match // high while match holds
);
    import tsc_pkg::*;
    tsc_match_state_type st_q, st_d;
    logic [5:0] len;
    logic [W-1:0] mask, ref_bits, diff;
    logic [5:0] errs;
    logic over_tol;

    // compare the newest len bits against the first len pattern bits
    always_comb begin
        st_d = st_q;
        len = {1'b0, length_sel, 3'b000} + 6'h08;
        mask = ~({W{1'b1}} << len);
        ref_bits = pattern >> (6'h20 - len);
        diff = (st_q.hist ^ ref_bits) & mask;
        errs = 6'h00;
        for (int i = 0; i < W; i++) begin
            errs = errs + {5'h00, diff[i]};
        end
        over_tol = errs > {4'h0, tolerance};
        if (!enable) begin
            st_d.hist = '0;
            st_d.fill = 6'h00;
            st_d.match = 1'b0;
        end else begin
            if (bit_valid) begin
                st_d.hist = {st_q.hist[W-2:0], bit_in};
                if (st_q.fill != 6'h20) begin
                    st_d.fill = st_q.fill + 6'h01;
                end
            end
            st_d.match = (st_q.fill >= len) && !over_tol;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign match = st_q.match;

    match_off_a: assert property (@(posedge clock) disable iff (rst)
        !enable |=> !match) else $error("match high while disabled");
    match_tol_a: assert property (@(posedge clock) disable iff (rst)
        over_tol |=> !match) else $error("match despite too many errors");
endmodule

// >>> tsc_clock_divider.sv
// divider of the reference clock for the clock output pin
`timescale 1ns/100ps
`include "tsc_map.svh"
module tsc_clock_divider (
    input wire logic clock, // system clock
    input wire logic rst, // synchronous reset
    input wire logic ref_clk, // reference clock level, sampled
    input wire logic enable, // output on and not asleep
    input wire logic [1:0] div_sel, // 00:/32 01:/16 10:/8 11:/4
    output logic clk_out // divided clock
);
    import tsc_pkg::*;
    tsc_div_state_type st_q, st_d;
    logic [4:0] half;
    logic ref_rise;

    // toggle every half ratio of reference rising edges
    always_comb begin
        st_d = st_q;
        st_d.ref_q = ref_clk;
        ref_rise = ref_clk && !st_q.ref_q;
        half = `TSC_DIV_HALF_MAX >> div_sel;
        if (!enable) begin
            st_d.cnt = 5'h00;
            st_d.out = 1'b0;
        end else if (ref_rise) begin
            if (st_q.cnt == half - 5'h01) begin
                st_d.cnt = 5'h00;
                st_d.out = ~st_q.out;
            end else begin
                st_d.cnt = st_q.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign clk_out = st_q.out;

    clk_stop_a: assert property (@(posedge clock) disable iff (rst)
        !enable |=> !clk_out) else $error("clock out runs while off");
    edge_only_a: assert property (@(posedge clock) disable iff (rst)
        (enable && !ref_rise) |=> $stable(clk_out))
        else $error("clock out moved without reference edge");
endmodule

// >>> tsc_serial_port.sv
// three-wire serial configuration port with shadow and active bytes
//
// Behaviour
// - in a write, serial input shifts in on each falling serial clock
// - read bits appear from a rising edge; host samples next fall
// - writes land in shadow bytes; active bytes load at enable rise
// - frame starts with serial input low over one serial clock
// - write: start, direction 0, 5 address bits msb first, 8 data, 2 stops
// - transfer ends after second stop; idle ones are not frame content
// - several writes accepted within one low enable period
// - read: start, direction 1, 5 address bits, then byte shifted out
// - serial output is zero except while read data goes out
// - bytes 00-01 rx/tx, 02-04 frequency, 05 status, 06-07 extra, 08-0B pattern
// - pattern compare needs match enable and bit sync on
// - match output high when errors within tolerance, else low
// - match output low while pattern matching is off
// - clock output is reference divided by 4, 8, 16 or 32
// - clock output stops while mode is sleep 000
// - staircase bit picks 10 or 20 percent edge time, only with prefilter on
// - byte 00 holds sensitivity, bit sync, strength, freq error, bw, power
// - byte 01 holds source, wakeup, prefilter, method, ratio, inhibit, range, clock
// - divider code 00 /32, 01 /16, 10 /8, 11 /4
// - own 2-bit tolerance field, codes 0 to 3 errors
// - length code 00 8, 01 16, 10 24, 11 32 bits
`timescale 1ns/100ps
`include "tsc_map.svh"
module tsc_serial_port (
    input wire logic clock, // system clock, 100 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic sck, // serial clock from host
    input wire logic si, // serial data in
    input wire logic en_n, // frame enable, active low
    output logic so, // serial data out
    input wire logic [2:0] mode, // operating mode, 000 is sleep
    input wire tsc_pkg::tsc_byte_type status, // live transceiver status
    input wire logic ref_clk, // reference clock level
    input wire logic rx_bit, // recovered receive bit
    input wire logic rx_bit_valid, // strobe per received bit
    output logic [15:0] rx_tx_config, // active bytes 00 (msb), 01
    output logic [23:0] frequency_config, // active bytes 02 (msb)..04
    output logic [15:0] extra_config, // active bytes 06 (msb), 07
    output logic edge_ratio_select, // 1: 20 percent edges
    output logic clk_out, // divided reference clock
    output logic pattern_match // pattern detected
);
    import tsc_pkg::*;

    tsc_port_state_type st_q, st_d;
    // pin samples reset to the idle-high levels so no false edge follows
    localparam tsc_port_state_type PORT_RESET =
        {2'b11, {($bits(tsc_port_state_type) - 2){1'b0}}};
    logic sck_fall;
    logic sck_rise;
    logic en_rise;
    logic wr_ok;
    logic [4:0] next_addr;
    logic [31:0] pattern_bits;
    logic [7:0] rx_tx_b0, rx_tx_b1, extra_b0;
    logic match_on;
    logic clk_on;
    logic [7:0] shadow_at_addr;
    logic read_msb;

    // byte returned for a read address
    function automatic logic [7:0] read_value(
        input logic [4:0] a,
        input logic [7:0] stat,
        input logic [`TSC_NUM_BYTES-1:0][7:0] regs
    );
        logic [7:0] v;
        v = 8'h00;
        // status byte shows live state, other mapped bytes the shadow copy
        if (a == `TSC_ADDR_STATUS) begin
            v = stat;
        end else if (a <= `TSC_ADDR_PAT3) begin
            v = regs[a[3:0]];
        end
        // test and unmapped bytes read as zero
        return v;
    endfunction

    // edges of the host pins, taken as synchronous inputs
    assign sck_fall = st_q.sck_q && !sck;
    assign sck_rise = !st_q.sck_q && sck;
    assign en_rise = !st_q.en_n_q && en_n;

    // only mapped writable bytes take writes; status is read only
    assign wr_ok = (st_q.addr <= `TSC_ADDR_PAT3) &&
        (st_q.addr != `TSC_ADDR_STATUS);
    assign next_addr = {st_q.addr[3:0], si};

    // frame decoder and register bank
    always_comb begin
        st_d = st_q;
        st_d.sck_q = sck;
        st_d.en_n_q = en_n;
        // commit shadow to active only on enable rise
        if (en_rise) begin
            st_d.active = st_q.shadow;
        end
        // enable high aborts any frame, nothing is stored
        if (en_n) begin
            st_d.state = TSC_IDLE;
            st_d.cnt = 3'h0;
            st_d.so = 1'b0;
        end else begin
            case (st_q.state)
                TSC_IDLE: begin
                    // low on a falling edge is the start bit
                    if (sck_fall && !si) begin
                        st_d.state = TSC_DIR;
                    end
                end
                TSC_DIR: begin
                    if (sck_fall) begin
                        st_d.rw = si;
                        st_d.cnt = 3'h0;
                        st_d.state = TSC_ADDR;
                    end
                end
                TSC_ADDR: begin
                    // address shifts in msb first on falls
                    if (sck_fall) begin
                        st_d.addr = next_addr;
                        if (st_q.cnt == `TSC_ADDR_LAST) begin
                            st_d.cnt = 3'h0;
                            if (st_q.rw) begin
                                st_d.data = read_value(next_addr,
                                    status, st_q.shadow);
                                st_d.state = TSC_READ;
                            end else begin
                                st_d.state = TSC_DATA;
                            end
                        end else begin
                            st_d.cnt = st_q.cnt + 3'h1;
                        end
                    end
                end
                TSC_DATA: begin
                    if (sck_fall) begin
                        st_d.data = {st_q.data[6:0], si};
                        if (st_q.cnt == `TSC_DATA_LAST) begin
                            st_d.cnt = 3'h0;
                            st_d.state = TSC_STOP;
                        end else begin
                            st_d.cnt = st_q.cnt + 3'h1;
                        end
                    end
                end
                TSC_STOP: begin
                    // a zero stop bit breaks the frame and drops it
                    if (sck_fall) begin
                        if (!si) begin
                            st_d.state = TSC_IDLE;
                        end else if (st_q.cnt == `TSC_STOP_LAST) begin
                            // store and wait for the next start
                            if (wr_ok) begin
                                st_d.shadow[st_q.addr[3:0]] = st_q.data;
                            end
                            st_d.state = TSC_IDLE;
                        end else begin
                            st_d.cnt = st_q.cnt + 3'h1;
                        end
                    end
                end
                TSC_READ: begin
                    // drive on rise, advance after the host samples
                    if (sck_rise) begin
                        st_d.so = st_q.data[7];
                    end else if (sck_fall) begin
                        st_d.data = {st_q.data[6:0], 1'b0};
                        if (st_q.cnt == `TSC_DATA_LAST) begin
                            // back to zero after the last bit
                            st_d.so = 1'b0;
                            st_d.cnt = 3'h0;
                            st_d.state = TSC_IDLE;
                        end else begin
                            st_d.cnt = st_q.cnt + 3'h1;
                        end
                    end
                end
                default: begin
                    st_d.state = TSC_IDLE;
                    st_d.so = 1'b0;
                end
            endcase
        end
    end

    // one register for the whole port state
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= PORT_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign rx_tx_b0 = st_q.active[`TSC_ADDR_RXTX0];
    assign rx_tx_b1 = st_q.active[`TSC_ADDR_RXTX1];
    assign extra_b0 = st_q.active[`TSC_ADDR_EXTRA0];
    assign rx_tx_config = {rx_tx_b0, rx_tx_b1};
    assign frequency_config = {st_q.active[`TSC_ADDR_FREQ0],
        st_q.active[`TSC_ADDR_FREQ1], st_q.active[`TSC_ADDR_FREQ2]};
    assign extra_config = {extra_b0, st_q.active[`TSC_ADDR_EXTRA1]};
    assign pattern_bits = {st_q.active[`TSC_ADDR_PAT0],
        st_q.active[`TSC_ADDR_PAT1], st_q.active[`TSC_ADDR_PAT2],
        st_q.active[`TSC_ADDR_PAT3]};
    assign so = st_q.so;

    // ratio only matters with prefilter on; 0 means 10 percent
    assign edge_ratio_select = rx_tx_b1[`TSC_RXTX1_PREF] &&
        rx_tx_b1[`TSC_RXTX1_STAIR];

    // matcher runs only with bit sync on as well
    assign match_on = extra_b0[`TSC_EXTRA0_MATCH] &&
        rx_tx_b0[`TSC_RXTX0_BSYNC];

    // sleep stops the clock output regardless of its enable
    assign clk_on = rx_tx_b1[`TSC_RXTX1_CLKOUT] &&
        (mode != `TSC_MODE_SLEEP);

    tsc_pattern_match #(
        .W(`TSC_PAT_BITS)
    ) u_match (
        .clock(clock),
        .rst(rst),
        .enable(match_on),
        .bit_in(rx_bit),
        .bit_valid(rx_bit_valid),
        .pattern(pattern_bits),
        .length_sel(extra_b0[`TSC_EXTRA0_LEN_HI:`TSC_EXTRA0_LEN_LO]),
        .tolerance(extra_b0[`TSC_EXTRA0_TOL_HI:`TSC_EXTRA0_TOL_LO]),
        .match(pattern_match)
    );

    tsc_clock_divider u_div (
        .clock(clock),
        .rst(rst),
        .ref_clk(ref_clk),
        .enable(clk_on),
        .div_sel(extra_b0[`TSC_EXTRA0_DIV_HI:`TSC_EXTRA0_DIV_LO]),
        .clk_out(clk_out)
    );

    // helpers read only by the checks below
    assign shadow_at_addr = st_q.shadow[st_q.addr[3:0]];
    assign read_msb = st_q.data[7];

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence start_bit;
        st_q.state == TSC_IDLE && !en_n && sck_fall && !si;
    endsequence

    sequence stop_done;
        st_q.state == TSC_STOP && st_q.cnt == `TSC_STOP_LAST &&
            sck_fall && si && !en_n;
    endsequence

    sequence read_rise;
        st_q.state == TSC_READ && sck_rise && !en_n;
    endsequence

    start_detect_a: assert property (
        start_bit |=> st_q.state == TSC_DIR)
        else $error("start bit not taken");

    shift_in_a: assert property (
        (st_q.state == TSC_DATA && sck_fall && !en_n)
        |=> st_q.data[0] == $past(si))
        else $error("data bit not shifted on fall");

    write_store_a: assert property (
        (stop_done ##0 wr_ok) |=> shadow_at_addr == $past(st_q.data))
        else $error("completed write not stored");

    write_end_a: assert property (
        stop_done ##1 (si && !en_n) |-> st_q.state == TSC_IDLE)
        else $error("frame continued past stop bits");

    commit_a: assert property (
        en_rise |=> st_q.active == $past(st_q.shadow))
        else $error("active bytes not loaded at enable rise");

    active_hold_a: assert property (
        !en_rise |=> $stable(st_q.active))
        else $error("active bytes changed without enable rise");

    so_quiet_a: assert property (
        st_q.state != TSC_READ |-> !so)
        else $error("serial output high outside read");

    read_bit_a: assert property (
        read_rise |=> so == $past(read_msb) ##1 so == $past(read_msb, 2))
        else $error("read bit not presented at rise");

    abort_a: assert property (
        (en_n && st_q.state != TSC_IDLE) |=> st_q.state == TSC_IDLE &&
        $stable(st_q.shadow))
        else $error("aborted frame not discarded");

    // header fields, refused writes and the end of a read
    dir_take_a: assert property (
        (st_q.state == TSC_DIR && sck_fall && !en_n)
        |=> st_q.rw == $past(si) && st_q.state == TSC_ADDR)
        else $error("direction bit not taken");

    addr_shift_a: assert property (
        (st_q.state == TSC_ADDR && sck_fall && !en_n)
        |=> st_q.addr[0] == $past(si))
        else $error("address bit not shifted on fall");

    read_enter_a: assert property (
        (st_q.state == TSC_ADDR && st_q.cnt == `TSC_ADDR_LAST && st_q.rw &&
            sck_fall && !en_n) |=> st_q.state == TSC_READ)
        else $error("read frame did not reach data phase");

    read_done_a: assert property (
        (st_q.state == TSC_READ && st_q.cnt == `TSC_DATA_LAST && sck_fall &&
            !en_n) |=> !so && st_q.state == TSC_IDLE)
        else $error("serial output not released after last bit");

    refuse_write_a: assert property (
        (stop_done ##0 !wr_ok) |=> $stable(st_q.shadow))
        else $error("write to unmapped or status byte stored");

    shadow_hold_a: assert property (
        !(st_q.state == TSC_STOP && sck_fall) |=> $stable(st_q.shadow))
        else $error("shadow byte changed outside a stop bit");

    bad_stop_a: assert property (
        (st_q.state == TSC_STOP && sck_fall && !si && !en_n)
        |=> st_q.state == TSC_IDLE && $stable(st_q.shadow))
        else $error("frame with a zero stop bit kept");
endmodule

// >>> tsc_host_model.sv
// host model driving the config port's serial wires
`timescale 1ns/100ps
module tsc_host_model (
    input wire logic clock, // system clock
    input wire logic so, // data from port
    output logic sck, // serial clock
    output logic si, // serial data
    output logic en_n, // frame enable
    output logic reading // read data phase
);
    // a 100-clock serial period sits at the 1 MHz ceiling
    localparam int HALF = 50;
    initial begin
        sck = 1'b1;
        si = 1'b1;
        en_n = 1'b1;
        reading = 1'b0;
    end
    // si moves at the rise, so taken just before fall
    task automatic bit_cycle(input logic b, output logic s);
        @(negedge clock);
        si = b;
        sck = 1'b1;
        repeat (HALF) @(negedge clock);
        s = so;
        sck = 1'b0;
        repeat (HALF - 1) @(negedge clock);
    endtask
    task automatic send(input logic [16:0] f, input int n);
        logic s;
        for (int i = 16; i > 16 - n; i--) begin
            bit_cycle(f[i], s);
        end
    endtask
    // one high serial clock, then rest high
    task automatic idle();
        send(17'h1FFFF, 1);
        @(negedge clock);
        sck = 1'b1;
    endtask
    // enable moves only with the wires at rest
    task automatic set_en(input logic v);
        @(negedge clock);
        en_n = v;
        sck = 1'b1;
        si = 1'b1;
        repeat (HALF) @(negedge clock);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        send({2'b00, a, d, 2'b11}, 17);
        idle();
    endtask
    // si stays high while the port shifts its byte out
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        logic s;
        send({2'b01, a, 10'h3FF}, 7);
        reading = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            d[i] = s;
        end
        idle();
        reading = 1'b0;
    endtask
endmodule

// >>> tsc_serial_port_tb.sv
// self-checking bench for the serial config port
`timescale 1ns/100ps
module tsc_serial_port_tb;
    localparam logic [31:0] PAT = 32'hA53CF096;
    logic clock = 1'b0;
    logic rst;
    logic sck, si, en_n, so, reading, edge_ratio_select, clk_out;
    logic pattern_match;
    logic [2:0] mode;
    tsc_pkg::tsc_byte_type status;
    logic ref_clk;
    logic rx_bit;
    logic rx_bit_valid;
    logic [15:0] rx_tx_config, extra_config;
    logic [23:0] frequency_config;
    logic [7:0] rd;
    int num_errors = 0;
    int comparisons = 0;
    // free clock; the sampled reference toggles each cycle
    initial begin
        forever #5 clock = ~clock;
    end
    always @(negedge clock) ref_clk <= rst ? 1'b0 : ~ref_clk;
    tsc_serial_port u_dut (
        .clock(clock), .rst(rst), .sck(sck), .si(si), .en_n(en_n),
        .so(so), .mode(mode), .status(status), .ref_clk(ref_clk),
        .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
        .rx_tx_config(rx_tx_config), .frequency_config(frequency_config),
        .extra_config(extra_config), .edge_ratio_select(edge_ratio_select),
        .clk_out(clk_out), .pattern_match(pattern_match)
    );
    tsc_host_model u_host (
        .clock(clock), .so(so), .sck(sck), .si(si), .en_n(en_n),
        .reading(reading)
    );
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // about 68k cycles of traffic; a hang is cut off before 100k
    initial begin
        repeat (95000) @(posedge clock);
        num_errors++;
        wrap_up();
    end
    // serial output must rest low outside read data
    always @(negedge clock) begin
        if (!rst && !reading && so !== 1'b0) begin
            check("so rest", so, 1'b0);
        end
    end
    // one write in its own frame, committed by the enable rise
    task automatic cfg(input logic [4:0] a, input logic [7:0] d);
        u_host.set_en(1'b0);
        u_host.wr(a, d);
        u_host.set_en(1'b1);
        repeat (3) @(negedge clock);
    endtask
    task automatic t_reset();
        check("rxtx", rx_tx_config, 16'h0000);
        check("freq", frequency_config, 24'h000000);
        check("extra", extra_config, 16'h0000);
        check("outs", {clk_out, pattern_match}, 2'b00);
        $display("test reset done");
    endtask
    task automatic t_shadow();
        u_host.set_en(1'b0);
        u_host.wr(5'h00, 8'hA3);
        u_host.wr(5'h02, 8'h5C);
        u_host.wr(5'h03, 8'h81);
        u_host.wr(5'h04, 8'h7E);
        u_host.wr(5'h07, 8'h55);
        check("early", rx_tx_config, 16'h0000);
        u_host.rd(5'h00, rd);
        check("shadow", rd, 8'hA3);
        u_host.set_en(1'b1);
        repeat (3) @(negedge clock);
        check("rxtx", rx_tx_config, 16'hA300);
        check("freq", frequency_config, 24'h5C817E);
        check("extra", extra_config, 16'h0055);
        $display("test shadow done");
    endtask
    task automatic t_refuse();
        u_host.set_en(1'b0);
        u_host.wr(5'h0C, 8'h3C);
        u_host.rd(5'h0C, rd);
        check("unmapped", rd, 8'h00);
        u_host.rd(5'h05, rd);
        check("status", rd, 8'h96);
        status = 8'h69;
        u_host.rd(5'h05, rd);
        check("status new", rd, 8'h69);
        u_host.rd(5'h10, rd);
        check("test byte", rd, 8'h00);
        // a zero first stop bit drops the frame
        u_host.send({2'b00, 5'h00, 8'h5A, 2'b01}, 17);
        u_host.idle();
        u_host.set_en(1'b1);
        // enable rises after the first stop only
        u_host.set_en(1'b0);
        u_host.send({2'b00, 5'h00, 8'h5A, 2'b11}, 16);
        u_host.set_en(1'b1);
        repeat (3) @(negedge clock);
        check("cut active", rx_tx_config, 16'hA300);
        u_host.set_en(1'b0);
        u_host.rd(5'h00, rd);
        check("cut shadow", rd, 8'hA3);
        u_host.set_en(1'b1);
        $display("test refuse done");
    endtask
    task automatic t_ratio();
        logic [7:0] d;
        for (int k = 0; k < 4; k++) begin
            d = {2'b00, k[1], 1'b0, k[0], 3'b001};
            cfg(5'h01, d);
            check("ratio", edge_ratio_select, k == 3);
            check("rxtx1", rx_tx_config[7:0], d);
        end
        $display("test ratio done");
    endtask
    // last rise-to-rise spacing of clk_out, 0 when it is still
    task automatic period(output int p);
        int t0;
        logic prev;
        p = 0;
        t0 = -1;
        prev = 1'b1;
        for (int i = 0; i < 300; i++) begin
            @(negedge clock);
            if (clk_out === 1'b1 && prev === 1'b0) begin
                if (t0 >= 0) begin
                    p = i - t0;
                end
                t0 = i;
            end
            prev = clk_out;
        end
    endtask
    task automatic t_clk();
        int p;
        for (int s = 0; s < 4; s++) begin
            cfg(5'h06, {5'b00000, s[1:0], 1'b0});
            period(p);
            check("clk period", p, 2 * (32 >> s));
        end
        mode = 3'h0;
        period(p);
        check("sleep", p, 0);
        mode = 3'h1;
        cfg(5'h01, 8'h00);
        period(p);
        check("clk off", p, 0);
        $display("test clock done");
    endtask
    // feed the reference top bits with chosen errors flipped
    task automatic m_case(input logic [7:0] c6, input logic [31:0] err,
            input logic exp);
        int len;
        len = 8 * (c6[6:5] + 1);
        cfg(5'h06, c6);
        for (int i = 0; i < len; i++) begin
            @(negedge clock);
            rx_bit = PAT[31 - i] ^ err[31 - i];
            rx_bit_valid = 1'b1;
            @(negedge clock);
            rx_bit_valid = 1'b0;
        end
        repeat (3) @(negedge clock);
        check("match", pattern_match, exp);
    endtask
    task automatic t_match();
        u_host.set_en(1'b0);
        u_host.wr(5'h08, PAT[31:24]);
        u_host.wr(5'h09, PAT[23:16]);
        u_host.wr(5'h0A, PAT[15:8]);
        u_host.wr(5'h0B, PAT[7:0]);
        u_host.wr(5'h00, 8'hE3);
        u_host.set_en(1'b1);
        m_case(8'h80, 32'h00000000, 1'b1);
        m_case(8'h80, 32'h10000000, 1'b0);
        m_case(8'hA8, 32'h00010000, 1'b1);
        m_case(8'hF0, 32'h80000101, 1'b0);
        m_case(8'hD8, 32'h81000100, 1'b1);
        cfg(5'h00, 8'hA3);
        check("sync off", pattern_match, 1'b0);
        cfg(5'h00, 8'hE3);
        m_case(8'h00, 32'h00000000, 1'b0);
        $display("test match done");
    endtask
    // reset held ten cycles, then the tests in turn
    initial begin
        rst = 1'b1;
        mode = 3'h1;
        status = 8'h96;
        rx_bit = 1'b0;
        rx_bit_valid = 1'b0;
        repeat (10) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        t_reset();
        t_shadow();
        t_refuse();
        t_ratio();
        t_clk();
        t_match();
        wrap_up();
    end
endmodule
